// >>> rtl/wwd_pkg.sv
/*
 Package for the window watchdog and reset generator: timing constants,
 mode encodings and the packed status carrier.
 Assumes a single 40 MHz clock; all times are counted in cycles of it.

 // Operation
 // - Hold reset low for the reset delay after power-on, then release.
 // - Reset rising starts an ignore window that disregards the trigger input.
 // - Ignore window end starts a long open window of four standard windows.
 // - Valid trigger in long open window starts a closed window at once.
 // - A falling edge on the trigger input is the trigger event.
 // - Valid trigger: two high samples then two low, sampled every 0.5 ms.
 // - Closed window end starts a standard open window at once.
 // - Valid trigger ends the standard open window at once.
 // - No trigger before standard open window ends asserts reset.
 // - Trigger during a closed window asserts reset.
 // - Output voltage below threshold drives reset low.
 // - On the 3.3 V variant, low input voltage also asserts reset.
 // - Watchdog state slow, fast or off comes from two mode pins.
 // - Enable input switches the regulator on or off.
 // - Thermal shutdown turns the regulator off.
 // - Fast reset delay only when both mode pins low, slow otherwise.
 // - Watchdog off while load current is low, back on when it rises.
*/
package wwd_pkg;
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned SAMPLE_US = 500;
   localparam int unsigned SAMPLE_CYC = (CLK_HZ / 1_000_000) * SAMPLE_US;
   // Window lengths in ms; the top converts them to 0.5 ms ticks
   localparam int unsigned RESET_DELAY_FAST_MS = 16;
   localparam int unsigned RESET_DELAY_SLOW_MS = 32;
   localparam int unsigned WINDOW_FAST_MS = 32;
   localparam int unsigned WINDOW_SLOW_MS = 64;
   localparam int unsigned LONG_OPEN_MULT = 4;
   localparam int unsigned TICKS_PER_MS = 2;
   localparam int unsigned TICK_W = 10;
   localparam int unsigned SAMPLE_W = 16;

   typedef enum logic [1:0] {
      WWD_MODE_FAST = 2'b00,
      WWD_MODE_SLOW = 2'b01,
      WWD_MODE_OFF  = 2'b10
   } wwd_mode_t;

   typedef enum logic [2:0] {
      WWD_ST_RESET  = 3'b000,
      WWD_ST_IGNORE = 3'b001,
      WWD_ST_LONG   = 3'b010,
      WWD_ST_CLOSED = 3'b011,
      WWD_ST_OPEN   = 3'b100
   } wwd_state_t;

   typedef struct packed {
      logic vout_low;
      logic vin_low;
      logic enable;
      logic thermal_sd;
      logic load_low;
      logic load_high;
   } wwd_status_t;
endpackage

// >>> rtl/wwd_sync.sv
/*
 Two flip-flop synchroniser for a bus of asynchronous levels.
 Assumes inputs come from pins or analog comparators outside clk.
*/
`timescale 1ns/100ps
`default_nettype none
module wwd_sync #(
   parameter int unsigned WIDTH = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Data
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule
`default_nettype wire

// >>> rtl/wwd_trigger_det.sv
/*
 Trigger decoder: samples the synchronised trigger line once per tick and
 flags a valid falling trigger (high, high, low, low).
 Assumes tick is a one-cycle pulse every 0.5 ms on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module wwd_trigger_det
   import wwd_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Sampling
   input wire logic tick,
   input wire logic trig_sync,
   // Result
   output logic valid_trig
);
   logic [3:0] hist;
   logic [3:0] next_hist;
   wire pattern_hit;

   assign next_hist = {hist[2:0], trig_sync};
   // Oldest two high, newest two low marks a falling edge
   assign pattern_hit = tick && (next_hist == 4'b1100);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hist <= 4'h0;
         valid_trig <= 1'b0;
      end else begin
         if (tick) begin
            hist <= next_hist;
         end
         valid_trig <= pattern_hit;
      end
   end
endmodule
`default_nettype wire

// >>> rtl/wwd_top.sv
/*
 Window watchdog and reset generator. Holds the processor reset, runs the
 ignore, long open, closed and open windows, and gates the regulator.
 Assumes all status inputs and pins are asynchronous and pass a
 synchroniser; the processor drives trigger pulses at the nominal period.
*/
`timescale 1ns/100ps
`default_nettype none
module wwd_top
   import wwd_pkg::*;
#(
   parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYC,
   parameter logic IS_3V3 = 1'b0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Processor side
   input wire logic wd_trigger_in,
   output logic reset_out_n,
   output logic reset_out_oe,
   // Strap pins
   input wire logic mode_sel_a,
   input wire logic mode_sel_b,
   // Analog comparator status
   input wire logic vout_low,
   input wire logic vin_low,
   input wire logic enable_in,
   input wire logic thermal_sd,
   input wire logic load_low,
   input wire logic load_high,
   // Regulator and observation
   output logic regulator_on,
   output logic wd_active,
   output logic [2:0] wd_state
);
   // ----------------------------------------------------------------
   // Synchronisers
   // ----------------------------------------------------------------
   wwd_status_t stat_raw;
   wwd_status_t stat;
   logic [2:0] pins_sync;
   logic trig_s;
   logic sel_a_s;
   logic sel_b_s;

   assign stat_raw = '{vout_low: vout_low, vin_low: vin_low, enable: enable_in,
                       thermal_sd: thermal_sd, load_low: load_low,
                       load_high: load_high};

   wwd_sync #(.WIDTH(6)) u_stat_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d(stat_raw),
      .q(stat)
   );

   wwd_sync #(.WIDTH(3)) u_pin_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d({wd_trigger_in, mode_sel_a, mode_sel_b}),
      .q(pins_sync)
   );

   assign trig_s = pins_sync[2];
   assign sel_a_s = pins_sync[1];
   assign sel_b_s = pins_sync[0];

   // ----------------------------------------------------------------
   // Mode decode and durations
   // ----------------------------------------------------------------
   wwd_mode_t mode;
   logic fast;
   logic [TICK_W-1:0] delay_ticks;
   logic [TICK_W-1:0] win_ticks;
   logic [TICK_W-1:0] long_ticks;

   function automatic logic [TICK_W-1:0] ms_ticks(input int unsigned ms);
      ms_ticks = TICK_W'(ms * TICKS_PER_MS);
   endfunction

   // Both low is fast, low/high is slow, a high on select A turns it off
   assign mode = sel_a_s ? WWD_MODE_OFF :
                 (sel_b_s ? WWD_MODE_SLOW : WWD_MODE_FAST);
   assign fast = !sel_a_s && !sel_b_s;
   assign delay_ticks = fast ? ms_ticks(RESET_DELAY_FAST_MS)
                             : ms_ticks(RESET_DELAY_SLOW_MS);
   assign win_ticks = (mode == WWD_MODE_SLOW) ? ms_ticks(WINDOW_SLOW_MS)
                                               : ms_ticks(WINDOW_FAST_MS);
   assign long_ticks = TICK_W'(win_ticks * LONG_OPEN_MULT);

   // ----------------------------------------------------------------
   // Sample tick
   // ----------------------------------------------------------------
   logic [SAMPLE_W-1:0] pre;
   logic tick;

   assign tick = (pre == SAMPLE_W'(SAMPLE_CYCLES - 1));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre <= '0;
      end else begin
         pre <= tick ? '0 : pre + SAMPLE_W'(1);
      end
   end

   // ----------------------------------------------------------------
   // Trigger decoder
   // ----------------------------------------------------------------
   logic valid_trig;

   wwd_trigger_det u_trig (
      .clk(clk),
      .rst_n(rst_n),
      .tick(tick),
      .trig_sync(trig_s),
      .valid_trig(valid_trig)
   );

   // ----------------------------------------------------------------
   // Watchdog enable from load current
   // ----------------------------------------------------------------
   logic load_ok;

   // Hysteresis: hold the last decision between the two thresholds
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         load_ok <= 1'b1;
      end else if (stat.load_low) begin
         load_ok <= 1'b0;
      end else if (stat.load_high) begin
         load_ok <= 1'b1;
      end
   end

   logic supply_fault;
   logic wd_on;

   assign supply_fault = stat.vout_low || (IS_3V3 && stat.vin_low);
   assign wd_on = load_ok && (mode != WWD_MODE_OFF);

   // ----------------------------------------------------------------
   // Window state machine
   // ----------------------------------------------------------------
   wwd_state_t state;
   wwd_state_t next_state;
   logic [TICK_W-1:0] cnt;
   logic [TICK_W-1:0] next_cnt;
   logic expired;

   assign expired = tick && (cnt == TICK_W'(1));

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      if (tick && cnt != '0) begin
         next_cnt = cnt - TICK_W'(1);
      end
      if (supply_fault) begin
         // Undervoltage restarts the delay so release waits a full period
         next_state = WWD_ST_RESET;
         next_cnt = delay_ticks;
      end else begin
         unique case (state)
            WWD_ST_RESET: begin
               if (expired) begin
                  next_state = WWD_ST_IGNORE;
                  next_cnt = win_ticks;
               end else if (tick && cnt > delay_ticks) begin
                  // Straps have settled by the first tick; trim to the fast delay
                  next_cnt = delay_ticks - TICK_W'(1);
               end
            end
            WWD_ST_IGNORE: begin
               // Trigger activity is not looked at here
               if (expired) begin
                  next_state = WWD_ST_LONG;
                  next_cnt = long_ticks;
               end
            end
            WWD_ST_LONG: begin
               if (!wd_on) begin
                  next_cnt = long_ticks;
               end else if (valid_trig) begin
                  next_state = WWD_ST_CLOSED;
                  next_cnt = win_ticks;
               end else if (expired) begin
                  next_state = WWD_ST_RESET;
                  next_cnt = delay_ticks;
               end
            end
            WWD_ST_CLOSED: begin
               if (!wd_on) begin
                  next_state = WWD_ST_LONG;
                  next_cnt = long_ticks;
               end else if (valid_trig) begin
                  next_state = WWD_ST_RESET;
                  next_cnt = delay_ticks;
               end else if (expired) begin
                  next_state = WWD_ST_OPEN;
                  next_cnt = win_ticks;
               end
            end
            WWD_ST_OPEN: begin
               if (!wd_on) begin
                  next_state = WWD_ST_LONG;
                  next_cnt = long_ticks;
               end else if (valid_trig) begin
                  next_state = WWD_ST_CLOSED;
                  next_cnt = win_ticks;
               end else if (expired) begin
                  next_state = WWD_ST_RESET;
                  next_cnt = delay_ticks;
               end
            end
            default: begin
               next_state = WWD_ST_RESET;
               next_cnt = delay_ticks;
            end
         endcase
      end
   end

   // Count loads at the slow delay on reset; the first tick trims it if fast
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= WWD_ST_RESET;
         cnt <= TICK_W'(RESET_DELAY_SLOW_MS * TICKS_PER_MS);
      end else begin
         state <= next_state;
         cnt <= next_cnt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   logic next_reg_on;

   assign next_reg_on = stat.enable && !stat.thermal_sd;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reset_out_n <= 1'b0;
         reset_out_oe <= 1'b1;
         regulator_on <= 1'b0;
         wd_active <= 1'b0;
         wd_state <= 3'h0;
      end else begin
         // Open drain: drive low only while reset is held
         reset_out_n <= (next_state != WWD_ST_RESET);
         reset_out_oe <= (next_state == WWD_ST_RESET);
         regulator_on <= next_reg_on;
         wd_active <= wd_on;
         wd_state <= next_state;
      end
   end
endmodule
`default_nettype wire

// >>> bench/wwd_top_chk.sv
/*
 Port checker for wwd_top: window order, reset pin, supply and strap effects.
 Bound to every wwd_top; tick length comes in through SAMPLE_CYCLES.
*/
`timescale 1ns/100ps
`default_nettype none
module wwd_top_chk
   import wwd_pkg::*;
#(
   parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYC,
   parameter logic IS_3V3 = 1'b0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Watched ports
   input wire logic reset_out_n,
   input wire logic reset_out_oe,
   input wire logic mode_sel_a,
   input wire logic vout_low,
   input wire logic vin_low,
   input wire logic load_low,
   input wire logic wd_active,
   input wire logic [2:0] wd_state
);
   // One tick of slack: the delay counts tick boundaries
   localparam int unsigned MIN_HOLD = 31 * SAMPLE_CYCLES;
   logic [31:0] low_cnt;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         low_cnt <= 32'h0000_0000;
      end else begin
         low_cnt <= reset_out_n ? 32'h0000_0000 : low_cnt + 32'h0000_0001;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // ----------
   // Properties
   // ----------
   sequence s_leave(logic [2:0] st);
      $past(wd_state) == st && wd_state != st;
   endsequence
   // Parking on a disabled watchdog and the flag drop share a clock edge; the check allows the flag two cycles more
   sequence s_off;
      ##[0:2] !wd_active;
   endsequence
   property p_hold;
      $rose(reset_out_n) |-> low_cnt >= MIN_HOLD;
   endproperty
   a_hold: assert property (p_hold) else $error("reset released early");
   property p_ign;
      s_leave(3'h0) |-> wd_state == 3'h1 && reset_out_n;
   endproperty
   a_ign: assert property (p_ign) else $error("no ignore after reset");
   property p_cw;
      s_leave(3'h2) |-> wd_state inside {3'h3, 3'h0};
   endproperty
   a_cw: assert property (p_cw) else $error("bad exit of long window");
   property p_ow;
      s_leave(3'h3) |-> (wd_state inside {3'h4, 3'h0}) or s_off;
   endproperty
   a_ow: assert property (p_ow) else $error("bad exit of closed window");
   property p_next;
      s_leave(3'h4) |-> (wd_state inside {3'h3, 3'h0}) or s_off;
   endproperty
   a_next: assert property (p_next) else $error("bad exit of open window");
   property p_pin;
      reset_out_oe != reset_out_n && (wd_state == 3'h0) == reset_out_oe;
   endproperty
   a_pin: assert property (p_pin) else $error("reset pin and state differ");
   property p_supply;
      (vout_low || (IS_3V3 && vin_low)) [*4] |-> !reset_out_n;
   endproperty
   a_supply: assert property (p_supply) else $error("no reset on supply low");
   property p_off;
      (mode_sel_a || load_low) [*6] |-> !wd_active;
   endproperty
   a_off: assert property (p_off) else $error("watchdog not disabled");
endmodule

bind wwd_top wwd_top_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES), .IS_3V3(IS_3V3)) u_chk (
   .clk(clk), .rst_n(rst_n), .reset_out_n(reset_out_n), .reset_out_oe(reset_out_oe),
   .mode_sel_a(mode_sel_a), .vout_low(vout_low), .vin_low(vin_low), .load_low(load_low),
   .wd_active(wd_active), .wd_state(wd_state)
);
`default_nettype wire

// >>> bench/wwd_cpu_model.sv
/*
 Processor model: falling-edge trigger pulses on a set period.
 Assumes the bench resolves the open-drain reset wire with its pull-up.
*/
`timescale 1ns/100ps
`default_nettype none
module wwd_cpu_model (
   // Clock and control
   input wire logic clk,
   input wire logic reset_wire_n,
   input wire logic trig_en,
   input wire logic [15:0] first_cyc,
   input wire logic [15:0] period_cyc,
   // Trigger line
   output logic wd_trigger_in
);
   logic [15:0] cnt;
   logic started;

   // Idle high, low for four ticks: two high then two low samples
   always @(posedge clk) begin
      if (!reset_wire_n || !trig_en) begin
         cnt <= 16'h0000;
         started <= 1'b0;
         wd_trigger_in <= 1'b1;
      end else if (cnt >= (started ? period_cyc : first_cyc)) begin
         // Period runs from one falling edge to the next
         cnt <= 16'h0001;
         started <= 1'b1;
         wd_trigger_in <= 1'b0;
      end else begin
         cnt <= cnt + 16'h0001;
         if (cnt == 16'h0010) begin
            wd_trigger_in <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// >>> bench/tb.sv
/*
 Self-checking bench for wwd_top with a processor model on the trigger line.
 Assumes a 4-clock sample tick, so window lengths are checked in clocks.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic clk = 1'b0, rst_n = 1'b0, trig_en = 1'b1;
   logic mode_sel_a = 1'b0, mode_sel_b = 1'b0, vout_low = 1'b0, vin_low = 1'b0;
   logic enable_in = 1'b1, thermal_sd = 1'b0, load_low = 1'b0, load_high = 1'b1;
   logic [15:0] period_cyc = 16'h0180;
   logic wd_trigger_in, reset_out_n, reset_out_oe, regulator_on, wd_active, reset_wire_n;
   logic [2:0] wd_state;
   int mismatches = 0, cmp_count = 0, n = 0, k = 0, lows = 0;

   always #12.5 clk = ~clk;
   assign reset_wire_n = reset_out_oe ? 1'b0 : 1'b1;

   wwd_top #(.SAMPLE_CYCLES(4), .IS_3V3(1'b1)) u_wwd_top (
      .clk(clk), .rst_n(rst_n), .wd_trigger_in(wd_trigger_in), .reset_out_n(reset_out_n),
      .reset_out_oe(reset_out_oe), .mode_sel_a(mode_sel_a), .mode_sel_b(mode_sel_b),
      .vout_low(vout_low), .vin_low(vin_low), .enable_in(enable_in), .thermal_sd(thermal_sd),
      .load_low(load_low), .load_high(load_high), .regulator_on(regulator_on),
      .wd_active(wd_active), .wd_state(wd_state)
   );
   wwd_cpu_model u_wwd_cpu_model (
      .clk(clk), .reset_wire_n(reset_wire_n), .trig_en(trig_en), .first_cyc(16'h0064),
      .period_cyc(period_cyc), .wd_trigger_in(wd_trigger_in)
   );

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Wait for a state, then check how many clocks it took
   task automatic win(input logic [2:0] st, input int lim, input int lo, input int hi);
      n = 0;
      while (wd_state !== st && n < lim) begin
         @(posedge clk);
         n++;
      end
      cmp_count++;
      if (n < lo || n > hi) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h to %h", $time, n, lo, hi);
      end
   endtask
   task automatic quiet(input int c);
      lows = 0;
      repeat (c) begin
         @(posedge clk);
         if (reset_out_n !== 1'b1) begin
            lows++;
         end
      end
      chk(lows[15:0], 16'h0000);
   endtask
   task automatic do_reset;
      rst_n <= 1'b0;
      repeat (12) @(posedge clk);
      chk({reset_out_n, regulator_on, wd_state}, 16'h0000);
      rst_n <= 1'b1;
   endtask
   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ---------
   // Scenarios
   // ---------
   initial begin
      do_reset;
      win(3'h1, 400, 120, 140);
      win(3'h2, 400, 248, 272);
      win(3'h3, 400, 220, 260);
      win(3'h4, 400, 248, 272);
      win(3'h3, 400, 116, 140);
      load_low <= 1'b1;
      enable_in <= 1'b0;
      repeat (8) @(posedge clk);
      chk({wd_active, regulator_on}, 16'h0000);
      load_low <= 1'b0;
      enable_in <= 1'b1;
      thermal_sd <= 1'b1;
      repeat (8) @(posedge clk);
      chk({wd_active, regulator_on}, 16'h0002);
      thermal_sd <= 1'b0;
      quiet(1500);
      chk(regulator_on, 1'b1);
      // Too short a period puts a pulse into a closed window
      period_cyc <= 16'h0080;
      win(3'h0, 1000, 0, 999);
      trig_en <= 1'b0;
      win(3'h1, 400, 120, 140);
      win(3'h2, 400, 248, 272);
      win(3'h0, 1100, 1016, 1040);
      trig_en <= 1'b1;
      period_cyc <= 16'h0180;
      win(3'h3, 1200, 0, 1199);
      trig_en <= 1'b0;
      win(3'h4, 300, 248, 272);
      win(3'h0, 300, 248, 272);
      for (k = 0; k < 2; k++) begin
         win(3'h1, 400, 0, 399);
         vout_low <= (k == 0);
         vin_low <= (k == 1);
         win(3'h0, 12, 1, 11);
         vout_low <= 1'b0;
         vin_low <= 1'b0;
         win(3'h1, 400, 120, 140);
      end
      mode_sel_b <= 1'b1;
      do_reset;
      win(3'h1, 600, 248, 272);
      vout_low <= 1'b1;
      win(3'h0, 12, 1, 11);
      vout_low <= 1'b0;
      win(3'h1, 600, 248, 272);
      win(3'h2, 600, 504, 528);
      mode_sel_a <= 1'b1;
      mode_sel_b <= 1'b0;
      do_reset;
      win(3'h1, 600, 248, 272);
      chk(wd_active, 1'b0);
      quiet(3500);
      close_out;
   end

   initial begin
      repeat (40000) @(posedge clk);
      mismatches++;
      close_out;
   end
endmodule
`default_nettype wire
